// ===== smcd_decoder.sv
// bus slave receiver, mode code decoder and split frequency divider
//
// Contract
// - codes 1, B, F: mute, transparent, scramble
// - codes 2..A pick nine split frequencies
// - code arrives inside a serial bus byte
// - reset clears and blocks all logic
// - all timing from 3.58 MHz oscillator; logic runs on clock, only the split divider counts oscillator rises
// - new split selection up to ten/s
// - transparent: no inversion, band limit only
// - slave receiver only, write bit zero
// - seven-bit address, low bit from pin
`timescale 1ns/100ps
`include "smcd_map.svh"
module smcd_decoder import smcd_pkg::*; #(
	// upper address bits; value is arbitrary
	parameter logic [5:0] ADDR_HI = 6'h24,
	parameter int DIV_W = 12
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// serial bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output smcd_pin_drive_t sda_drive,
	// straps and time base
	input wire logic address_select_pin,
	input wire logic oscillator_input,
	// analog path steering
	output smcd_path_t path,
	output logic [3:0] split_sel,
	output logic split_frequency
);

	// ******************************
	// input synchronisers
	// ******************************
	logic [1:0] bus_s;
	logic [1:0] misc_s;
	logic scl_s;
	logic sda_s;
	logic osc_s;
	logic asel_s;

	smcd_sync #(.W(2), .RST_VAL(2'h3)) u_bus_sync (
		.clock(clock),
		.nrst(nrst),
		.d({scl_i, sda_i}),
		.q(bus_s)
	);

	smcd_sync #(.W(2), .RST_VAL(2'h0)) u_misc_sync (
		.clock(clock),
		.nrst(nrst),
		.d({oscillator_input, address_select_pin}),
		.q(misc_s)
	);

	assign scl_s = bus_s[1];
	assign sda_s = bus_s[0];
	assign osc_s = misc_s[1];
	assign asel_s = misc_s[0];

	// ******************************
	// bus condition detection
	// ******************************
	logic scl_q_reg;
	logic sda_q_reg;
	logic osc_q_reg;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic osc_rise;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			scl_q_reg <= 1'h1;
			sda_q_reg <= 1'h1;
			osc_q_reg <= 1'h0;
		end else begin
			scl_q_reg <= scl_s;
			sda_q_reg <= sda_s;
			osc_q_reg <= osc_s;
		end
	end

	// sampling at 100 MHz leaves wide margin on a 100 kHz bus
	assign scl_rise = scl_s & ~scl_q_reg;
	assign scl_fall = ~scl_s & scl_q_reg;
	assign bus_start = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
	assign bus_stop = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
	assign osc_rise = osc_s & ~osc_q_reg;

	// ******************************
	// slave receiver
	// ******************************
	smcd_state_t state_reg, state_next;
	logic [7:0] shift_reg, shift_next;
	logic [3:0] bit_cnt_reg, bit_cnt_next;
	logic is_addr_reg, is_addr_next;
	logic ack_reg, ack_next;
	logic byte_done;
	logic addr_match;
	logic code_strobe;

	// the low address bit is the strap, only writes are acknowledged
	assign addr_match = (shift_reg[7:1] == {ADDR_HI, asel_s}) &&
		(shift_reg[0] == `SMCD_RW_WRITE);
	assign byte_done = (bit_cnt_reg == `SMCD_BITS_PER_BYTE);

	always_comb begin
		state_next = state_reg;
		shift_next = shift_reg;
		bit_cnt_next = bit_cnt_reg;
		is_addr_next = is_addr_reg;
		ack_next = ack_reg;
		code_strobe = 1'h0;
		if (bus_start) begin
			state_next = SMCD_ST_RX;
			bit_cnt_next = 4'h0;
			is_addr_next = 1'h1;
			ack_next = 1'h0;
		end else if (bus_stop) begin
			state_next = SMCD_ST_IDLE;
			ack_next = 1'h0;
		end else begin
			case (state_reg)
				SMCD_ST_RX: begin
					if (scl_rise && !byte_done) begin
						shift_next = {shift_reg[6:0], sda_s};
						bit_cnt_next = bit_cnt_reg + 4'h1;
					end else if (scl_fall && byte_done) begin
						bit_cnt_next = 4'h0;
						if (is_addr_reg && !addr_match) begin
							state_next = SMCD_ST_IGNORE;
						end else begin
							state_next = SMCD_ST_ACK;
							ack_next = 1'h1;
							code_strobe = ~is_addr_reg;
						end
					end
				end
				SMCD_ST_ACK: begin
					if (scl_fall) begin
						state_next = SMCD_ST_RX;
						is_addr_next = 1'h0;
						ack_next = 1'h0;
					end
				end
				SMCD_ST_IGNORE: begin
					state_next = SMCD_ST_IGNORE;
				end
				default: begin
					state_next = SMCD_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_reg <= SMCD_ST_IDLE;
			shift_reg <= 8'h00;
			bit_cnt_reg <= 4'h0;
			is_addr_reg <= 1'h1;
			ack_reg <= 1'h0;
		end else begin
			state_reg <= state_next;
			shift_reg <= shift_next;
			bit_cnt_reg <= bit_cnt_next;
			is_addr_reg <= is_addr_next;
			ack_reg <= ack_next;
		end
	end

	// open drain: only ever pulls low
	assign sda_drive.o = 1'h0;
	assign sda_drive.oe = ack_reg;

	// ******************************
	// mode decoding
	// ******************************
	smcd_mode_t mode_reg, mode_next;
	logic [3:0] split_reg, split_next;
	smcd_path_t path_reg, path_next;
	logic [3:0] code;

	assign code = shift_reg[3:0];

	always_comb begin
		mode_next = mode_reg;
		split_next = split_reg;
		// undefined codes change nothing
		if (code_strobe) begin
			if (code == `SMCD_CODE_MUTE) begin
				mode_next = SMCD_MODE_MUTE;
			end else if (code == `SMCD_CODE_TRANSPARENT) begin
				mode_next = SMCD_MODE_TRANSPARENT;
			end else if (code == `SMCD_CODE_SCRAMBLE) begin
				mode_next = SMCD_MODE_SCRAMBLE;
			end else if (code >= `SMCD_CODE_SPLIT_FIRST &&
				code <= `SMCD_CODE_SPLIT_LAST) begin
				// applied at once, far above ten per second
				split_next = code - `SMCD_CODE_SPLIT_FIRST;
			end
		end
		path_next.mute = (mode_next == SMCD_MODE_MUTE);
		path_next.invert_en = (mode_next == SMCD_MODE_SCRAMBLE);
		path_next.low_cut_en = (mode_next == SMCD_MODE_SCRAMBLE);
		path_next.band_limit_en = (mode_next != SMCD_MODE_MUTE);
	end

	// held until the next valid code
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			mode_reg <= SMCD_MODE_MUTE;
			split_reg <= `SMCD_SPLIT_RESET;
			path_reg <= '{mute: 1'h1, default: 1'h0};
		end else begin
			mode_reg <= mode_next;
			split_reg <= split_next;
			path_reg <= path_next;
		end
	end

	assign path = path_reg;
	assign split_sel = split_reg;

	// ******************************
	// split frequency divider
	// ******************************
	function automatic logic [DIV_W-1:0] half_cnt(input logic [3:0] idx);
		int freq_hz;
		case (idx)
			4'h0: freq_hz = `SMCD_SPLIT_HZ_0;
			4'h1: freq_hz = `SMCD_SPLIT_HZ_1;
			4'h2: freq_hz = `SMCD_SPLIT_HZ_2;
			4'h3: freq_hz = `SMCD_SPLIT_HZ_3;
			4'h4: freq_hz = `SMCD_SPLIT_HZ_4;
			4'h5: freq_hz = `SMCD_SPLIT_HZ_5;
			4'h6: freq_hz = `SMCD_SPLIT_HZ_6;
			4'h7: freq_hz = `SMCD_SPLIT_HZ_7;
			default: freq_hz = `SMCD_SPLIT_HZ_8;
		endcase
		return DIV_W'(`SMCD_OSC_HZ / (2 * freq_hz));
	endfunction

	logic [DIV_W-1:0] div_reg, div_next;
	logic split_clk_reg, split_clk_next;

	// counts oscillator rises only, so the system clock never sets the rate
	always_comb begin
		div_next = div_reg;
		split_clk_next = split_clk_reg;
		if (osc_rise) begin
			if (div_reg >= half_cnt(split_reg) - DIV_W'(1)) begin
				div_next = '0;
				split_clk_next = ~split_clk_reg;
			end else begin
				div_next = div_reg + DIV_W'(1);
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			div_reg <= '0;
			split_clk_reg <= 1'h0;
		end else begin
			div_reg <= div_next;
			split_clk_reg <= split_clk_next;
		end
	end

	assign split_frequency = split_clk_reg;

endmodule

// ===== smcd_map.svh
// constants of the scrambler mode command decoder
`ifndef SMCD_MAP_SVH
`define SMCD_MAP_SVH

// mode codes carried in the low nibble of a data byte
`define SMCD_CODE_MUTE 4'h1
`define SMCD_CODE_SPLIT_FIRST 4'h2
`define SMCD_CODE_SPLIT_LAST 4'hA
`define SMCD_CODE_TRANSPARENT 4'hB
`define SMCD_CODE_SCRAMBLE 4'hF

// bus framing and split reset index
`define SMCD_BITS_PER_BYTE 4'h8
`define SMCD_RW_WRITE 1'h0
`define SMCD_SPLIT_RESET 4'h0

// time base and split frequencies in Hz, highest first
`define SMCD_OSC_HZ 3580000
`define SMCD_SPLIT_HZ_0 2641
`define SMCD_SPLIT_HZ_1 1853
`define SMCD_SPLIT_HZ_2 1507
`define SMCD_SPLIT_HZ_3 1279
`define SMCD_SPLIT_HZ_4 1117
`define SMCD_SPLIT_HZ_5 1018
`define SMCD_SPLIT_HZ_6 899
`define SMCD_SPLIT_HZ_7 837
`define SMCD_SPLIT_HZ_8 767

`endif

// ===== smcd_pkg.sv
// types of the scrambler mode command decoder
package smcd_pkg;

	typedef enum logic [2:0] {
		SMCD_MODE_MUTE = 3'h1,
		SMCD_MODE_TRANSPARENT = 3'h2,
		SMCD_MODE_SCRAMBLE = 3'h4
	} smcd_mode_t;

	typedef enum logic [3:0] {
		SMCD_ST_IDLE = 4'h1,
		SMCD_ST_RX = 4'h2,
		SMCD_ST_ACK = 4'h4,
		SMCD_ST_IGNORE = 4'h8
	} smcd_state_t;

	// steering of the analog band path
	typedef struct packed {
		logic mute;
		logic invert_en;
		logic low_cut_en;
		logic band_limit_en;
	} smcd_path_t;

	// serial data pin as two signals
	typedef struct packed {
		logic o;
		logic oe;
	} smcd_pin_drive_t;

endpackage

// ===== smcd_sync.sv
// two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/100ps
module smcd_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;

	// first stage feeds only the second stage
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= RST_VAL;
			q_reg <= RST_VAL;
		end else begin
			meta_reg <= d;
			q_reg <= meta_reg;
		end
	end

	assign q = q_reg;

endmodule

// ===== smcd_decoder_chk.sv
// assertions on the mode decoder ports
`timescale 1ns/100ps
module smcd_chk import smcd_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// bus pins
	input wire logic scl_i,
	input smcd_pin_drive_t sda_drive,
	// time base and outputs
	input wire logic oscillator_input,
	input smcd_path_t path,
	input wire logic [3:0] split_sel,
	input wire logic split_frequency
);
	// ***
	// properties
	// ***
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// ack lasts at least three cycles, then lets go before the next byte
	sequence hold_s;
		sda_drive.oe [*3] ##[1:1000] !sda_drive.oe;
	endsequence
	property reset_p;
		disable iff (1'b0) !nrst |-> {path, split_sel} == 8'h80;
	endproperty
	property chg_p;
		$changed({path, split_sel}) |-> sda_drive.oe;
	endproperty
	// synchroniser delay leaves margin inside eight quiet cycles
	property osc_p;
		$stable(oscillator_input) [*8] |=> $stable(split_frequency);
	endproperty
	chk_pin_low: assert property (sda_drive.o == 1'b0)
		else $error("data pin driven high");
	chk_reset_state: assert property (reset_p)
		else $error("reset state wrong");
	chk_split_range: assert property (split_sel <= 4'h8)
		else $error("split index out of range");
	chk_path_legal: assert property (path inside {4'h8, 4'h1, 4'h7})
		else $error("path steering illegal");
	chk_change_acked: assert property (chg_p)
		else $error("mode changed outside a byte");
	chk_ack_span: assert property ($rose(sda_drive.oe) |-> hold_s)
		else $error("ack length wrong");
	chk_ack_scl_low: assert property ($rose(sda_drive.oe) |-> !scl_i)
		else $error("ack raised while clock high");
	chk_osc_time: assert property (osc_p)
		else $error("split output moved without time base");
endmodule

bind smcd_decoder smcd_chk smcd_chk_i (
	.clock(clock), .nrst(nrst), .scl_i(scl_i), .sda_drive(sda_drive),
	.oscillator_input(oscillator_input), .path(path),
	.split_sel(split_sel), .split_frequency(split_frequency)
);

// ===== smcd_master.sv
// bus master model driving the mode decoder
`timescale 1ns/100ps
module smcd_master (
	// clock
	input wire logic clock,
	// bus lines
	input wire logic sda_w,
	output logic scl,
	output logic sda
);
	// ***
	// bus cycles
	// ***
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask
	// data moves 300 ns after the clock falls, never with it
	task automatic bit1(input logic v, output logic s);
		wt(30);
		sda <= v;
		wt(440);
		scl <= 1'b1;
		wt(200);
		s = sda_w;
		wt(200);
		scl <= 1'b0;
	endtask
	// v high gives a start, v low a stop
	task automatic cond(input logic v);
		wt(30);
		sda <= v;
		wt(440);
		scl <= 1'b1;
		wt(470);
		sda <= ~v;
		wt(400);
		scl <= ~v;
	endtask
	task automatic put(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit1(b[i], s);
		end
		bit1(1'b1, s);
		ack = ~s;
	endtask
endmodule

// ===== smcd_decoder_tb_top.sv
// testbench of the scrambler mode command decoder
`timescale 1ns/100ps
`include "smcd_map.svh"
module smcd_decoder_tb_top import smcd_pkg::*;;
`define CHK(nm, e, a) begin \
	samples_checked++; \
	if ((a) !== (e)) begin \
		error_cnt++; \
		$display("MISMATCH %s exp %h got %h", nm, e, a); \
	end \
end
	// ***
	// bench
	// ***
	localparam logic [5:0] HI = 6'h24; // arbitrary upper address
	logic clock = 1'b0;
	logic nrst = 1'b1;
	logic scl, m_sda, sda_w, ack, osc = 1'b0, address_select_pin = 1'b0;
	smcd_pin_drive_t sda_drive;
	smcd_path_t path;
	logic [3:0] split_sel, code, exp_path = 4'h8, exp_sel = 4'h0;
	logic split_frequency;
	// slot 5 gets a random split code; split 0 stays long enough to time
	logic [3:0] codes[7] = '{4'hF, 4'hB, 4'h2, 4'h1, 4'hA, 4'h3,
		4'hF};
	int error_cnt = 0, samples_checked = 0, osc_cnt = 0;
	int split_n = 0, rise_n = 0, half_sel = -1, half_dsel = -1, half_exp;
	int split_hz[9] = '{`SMCD_SPLIT_HZ_0, `SMCD_SPLIT_HZ_1,
		`SMCD_SPLIT_HZ_2, `SMCD_SPLIT_HZ_3, `SMCD_SPLIT_HZ_4,
		`SMCD_SPLIT_HZ_5, `SMCD_SPLIT_HZ_6, `SMCD_SPLIT_HZ_7,
		`SMCD_SPLIT_HZ_8};
	logic split_q = 1'b0;
	assign sda_w = m_sda & ~sda_drive.oe;
	always #5 clock = ~clock;
	always @(posedge clock) begin
		osc_cnt <= (osc_cnt == 13) ? 0 : osc_cnt + 1;
		if (osc_cnt == 13) osc <= ~osc;
	end
	// half periods in oscillator rises, timed only when expected and decoded split index match those at the half's start
	always @(posedge clock) begin
		split_q <= split_frequency;
		if (!nrst) begin
			half_sel <= -1;
			rise_n <= 0;
		end else if (split_frequency !== split_q) begin
			if (half_sel == int'(exp_sel) &&
				half_dsel == int'(split_sel)) begin
				half_exp = `SMCD_OSC_HZ / (2 * split_hz[half_sel]);
				`CHK("split_half", half_exp, rise_n)
				split_n <= split_n + 1;
			end
			half_sel <= int'(exp_sel);
			half_dsel <= int'(split_sel);
			rise_n <= 0;
		end else if (osc_cnt == 13 && !osc) begin
			rise_n <= rise_n + 1;
		end
	end
	smcd_decoder #(.ADDR_HI(HI)) smcd_decoder_i (
		.clock(clock), .nrst(nrst), .scl_i(scl), .sda_i(sda_w),
		.sda_drive(sda_drive), .address_select_pin(address_select_pin),
		.oscillator_input(osc), .path(path), .split_sel(split_sel),
		.split_frequency(split_frequency)
	);
	smcd_master smcd_master_i (
		.clock(clock), .sda_w(sda_w), .scl(scl), .sda(m_sda)
	);
	task automatic look(input logic e_ack);
		`CHK("ack", e_ack, ack)
		`CHK("path", exp_path, path)
		`CHK("split_sel", exp_sel, split_sel)
	endtask
	task automatic report_and_stop();
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (99000) @(posedge clock);
		error_cnt++;
		report_and_stop();
	end
	initial begin
		nrst <= 1'b0;
		void'($urandom(59));
		codes[5] = 4'($urandom_range(10, 3));
		address_select_pin <= 1'($urandom);
		repeat (10) @(posedge clock);
		nrst <= 1'b1;
		repeat (5) @(posedge clock);
		`CHK("path", 4'h8, path)
		smcd_master_i.cond(1'b1);
		smcd_master_i.put({HI, address_select_pin, 1'b0}, ack);
		look(1'b1);
		// upper nibble is noise the decoder must ignore
		foreach (codes[i]) begin
			code = codes[i];
			smcd_master_i.put({4'($urandom), code}, ack);
			if (code == 4'h1) exp_path = 4'h8;
			else if (code == 4'hB) exp_path = 4'h1;
			else if (code == 4'hF) exp_path = 4'h7;
			else exp_sel = code - 4'h2;
			look(1'b1);
		end
		smcd_master_i.cond(1'b1);
		smcd_master_i.put({HI, ~address_select_pin, 1'b0}, ack);
		look(1'b0);
		smcd_master_i.put(8'h0B, ack);
		look(1'b0);
		smcd_master_i.cond(1'b1);
		smcd_master_i.put({HI, address_select_pin, 1'b1}, ack);
		look(1'b0);
		smcd_master_i.cond(1'b0);
		nrst <= 1'b0;
		repeat (2) @(posedge clock);
		`CHK("path", 4'h8, path)
		`CHK("split_sel", 4'h0, split_sel)
		`CHK("split_timed", 1'b1, split_n > 0)
		report_and_stop();
	end
endmodule
